// file: host_port_regs_pkg.sv
// Purpose: shared constants for the host port tag and rate limit registers
// Assumes: one 200 MHz clock, AXI4-Lite register access
// Notes: register index times four gives the byte address
package host_port_regs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int REG_N = 6;
  localparam int IDX_W = 10;
  localparam int CODE_W = 7;
  localparam int PRIO_N = 4;
  localparam int PRIO_W = 2;
  localparam int LEN_W = 11;
  localparam int COST_W = 13;
  localparam int ALLOW_W = 16;
  localparam int DIV_W = 16;
  localparam int VID_W = 12;

  // register indices
  localparam logic [IDX_W-1:0] IDX_DEFAULT_TAG = 10'h0A0;
  localparam logic [IDX_W-1:0] IDX_LIMIT_OPTIONS = 10'h0A2;
  localparam logic [IDX_W-1:0] IDX_INGRESS_RATE_LOW = 10'h0A4;
  localparam logic [IDX_W-1:0] IDX_INGRESS_RATE_HIGH = 10'h0A6;
  localparam logic [IDX_W-1:0] IDX_EGRESS_RATE_LOW = 10'h0A8;
  localparam logic [IDX_W-1:0] IDX_EGRESS_RATE_HIGH = 10'h0AA;
  localparam logic [REG_N-1:0][IDX_W-1:0] REG_IDX = {IDX_EGRESS_RATE_HIGH,
    IDX_EGRESS_RATE_LOW, IDX_INGRESS_RATE_HIGH, IDX_INGRESS_RATE_LOW,
    IDX_LIMIT_OPTIONS, IDX_DEFAULT_TAG};
  localparam int SEL_TAG = 0;
  localparam int SEL_OPT = 1;
  localparam int SEL_ING_LO = 2;
  localparam int SEL_ING_HI = 3;
  localparam int SEL_EG_LO = 4;
  localparam int SEL_EG_HI = 5;

  // reset values and writable bits
  localparam logic [REG_W-1:0] TAG_RST = 16'h0001;
  localparam logic [REG_W-1:0] ZERO_RST = 16'h0000;
  localparam logic [REG_N-1:0][REG_W-1:0] REG_RST = {ZERO_RST, ZERO_RST, ZERO_RST,
    ZERO_RST, ZERO_RST, TAG_RST};
  localparam logic [REG_N-1:0][REG_W-1:0] REG_WMASK = {16'h7F7F, 16'h7FFF, 16'h7F7F,
    16'h7F7F, 16'h00FF, 16'hFFFF};

  // field positions
  localparam int TAG_VID_LSB = 0;
  localparam int TAG_CFI_BIT = 12;
  localparam int TAG_PRI_LSB = 13;
  localparam int OPT_PRE_BIT = 0;
  localparam int OPT_GAP_BIT = 1;
  localparam int OPT_MODE_LSB = 2;
  localparam int RATE_LO_LSB = 0;
  localparam int RATE_HI_LSB = 8;
  localparam int EG_EN_BIT = 7;

  // ingress limit modes
  localparam logic [1:0] MODE_ALL = 2'h0;
  localparam logic [1:0] MODE_BMC_FLOOD = 2'h1;
  localparam logic [1:0] MODE_BMC = 2'h2;
  localparam logic [1:0] MODE_BCAST = 2'h3;

  // per-frame overhead bytes
  localparam logic [COST_W-1:0] GAP_BYTES = 13'h00C;
  localparam logic [COST_W-1:0] PRE_BYTES = 13'h008;

  // credit refill window
  localparam int CLK_PERIOD_NS = 5;
  localparam int REFILL_NS = 1000;
  localparam int REFILL_CYC = REFILL_NS / CLK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : host_port_regs_pkg

// file: rate_if.sv
// Purpose: config, frame event and verdict between port logic and a rate meter
// Assumes: same clock on both sides
// Notes: one instance per direction
`timescale 1ns/10ps
interface rate_if;
  logic [host_port_regs_pkg::PRIO_N-1:0][host_port_regs_pkg::CODE_W-1:0] code;
  logic [host_port_regs_pkg::PRIO_N-1:0][host_port_regs_pkg::ALLOW_W-1:0] allow;
  logic gap_en;
  logic pre_en;
  logic limit_en;
  logic frm_valid;
  logic [host_port_regs_pkg::PRIO_W-1:0] frm_prio;
  logic [host_port_regs_pkg::LEN_W-1:0] frm_len;
  logic frm_counted;
  logic res_done;
  logic res_pass;
  modport ctl(output code, allow, gap_en, pre_en, limit_en, frm_valid, frm_prio,
    frm_len, frm_counted, input res_done, res_pass);
  modport meter(input code, allow, gap_en, pre_en, limit_en, frm_valid, frm_prio,
    frm_len, frm_counted, output res_done, res_pass);
endinterface : rate_if

// file: default_tag_select.sv
// Purpose: pick the tag and lookup vid of an ingress frame
// Assumes: combinational, registered by the caller
// Notes: null vid counts as absent for lookup only
`timescale 1ns/10ps
module default_tag_select (
  input wire logic [host_port_regs_pkg::REG_W-1:0] def_tag,
  input wire logic frm_tagged,
  input wire logic [host_port_regs_pkg::REG_W-1:0] frm_tag,
  output logic [host_port_regs_pkg::REG_W-1:0] eff_tag,
  output logic [host_port_regs_pkg::VID_W-1:0] lookup_vid
);
  wire [host_port_regs_pkg::VID_W-1:0] frm_vid =
    frm_tag[host_port_regs_pkg::TAG_VID_LSB +: host_port_regs_pkg::VID_W];
  wire [host_port_regs_pkg::VID_W-1:0] def_vid =
    def_tag[host_port_regs_pkg::TAG_VID_LSB +: host_port_regs_pkg::VID_W];
  wire use_def_vid = !frm_tagged || (frm_vid == 12'h000);

  assign eff_tag = frm_tagged ? frm_tag : def_tag;
  assign lookup_vid = use_def_vid ? def_vid : frm_vid;
endmodule : default_tag_select

// file: rate_meter.sv
// Purpose: per-priority byte credit check for one direction
// Assumes: allowance per window comes from the external rate table
// Notes: buckets start empty and fill at the first window tick
`timescale 1ns/10ps
module rate_meter #(
  parameter int REFILL_CYC = host_port_regs_pkg::REFILL_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  rate_if.meter rif
);
  localparam int PN = host_port_regs_pkg::PRIO_N;
  localparam int AW = host_port_regs_pkg::ALLOW_W;
  localparam int CW = host_port_regs_pkg::COST_W;
  localparam int DW = host_port_regs_pkg::DIV_W;
  localparam int PW = host_port_regs_pkg::PRIO_W;

  logic [DW-1:0] div_reg;
  logic [AW-1:0] bucket_reg [PN];

  // window divider
  wire tick = div_reg == DW'(REFILL_CYC - 1);
  wire [CW-1:0] gap_add = rif.gap_en ? host_port_regs_pkg::GAP_BYTES : 13'h0000;
  wire [CW-1:0] pre_add = rif.pre_en ? host_port_regs_pkg::PRE_BYTES : 13'h0000;
  wire [CW-1:0] cost = CW'(rif.frm_len) + gap_add + pre_add;
  wire [AW-1:0] cost_w = AW'(cost);
  wire [AW-1:0] cur = bucket_reg[rif.frm_prio];
  wire code_zero = rif.code[rif.frm_prio] == 7'h00;
  wire charged = rif.frm_valid && rif.frm_counted && rif.limit_en && !code_zero;
  wire fits = cur >= cost_w;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= tick ? '0 : div_reg + 1'b1;
    end
  end

  for (genvar p = 0; p < PN; p++) begin : g_bucket
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        bucket_reg[p] <= '0;
      end else if (tick) begin
        bucket_reg[p] <= rif.allow[p];
      end else if (charged && fits && rif.frm_prio == PW'(p)) begin
        bucket_reg[p] <= bucket_reg[p] - cost_w;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rif.res_done <= 1'b0;
      rif.res_pass <= 1'b0;
    end else begin
      rif.res_done <= rif.frm_valid;
      rif.res_pass <= rif.frm_valid && (!charged || fits);
    end
  end

  property p_overhead_cost;
    @(posedge clk) disable iff (!arst_n)
    charged |=> rif.res_pass == ($past(cur) >= AW'($past(rif.frm_len))
      + ($past(rif.gap_en) ? 16'h000C : 16'h0000) + ($past(rif.pre_en) ? 16'h0008 : 16'h0000));
  endproperty
  a_overhead_cost: assert property (p_overhead_cost) else $error("overhead bytes wrong");

  property p_zero_code_free;
    @(posedge clk) disable iff (!arst_n)
    rif.frm_valid && code_zero |=> rif.res_done && rif.res_pass;
  endproperty
  a_zero_code_free: assert property (p_zero_code_free) else $error("zero code limited");

  property p_disabled_free;
    @(posedge clk) disable iff (!arst_n)
    rif.frm_valid && !rif.limit_en |=> rif.res_pass;
  endproperty
  a_disabled_free: assert property (p_disabled_free) else $error("disabled limit held");

  property p_over_rate_held;
    @(posedge clk) disable iff (!arst_n)
    charged && !fits |=> rif.res_done && !rif.res_pass;
  endproperty
  a_over_rate_held: assert property (p_over_rate_held) else $error("over rate passed");

  c_frame_held: cover property (@(posedge clk) disable iff (!arst_n) charged && !fits);
endmodule : rate_meter

// file: host_port_tag_rate_limit_regs.sv
// Purpose: host port default tag and rate limit registers with their datapath
// Assumes: AXI4-Lite slave, one clock, frame events from same-clock switch logic
// Notes: one write and one read outstanding; unmapped addresses answer SLVERR
//
// Contract
// - the default tag holds a 12-bit vid in bits 11-0 reset 0x001 and priority in 15-13 reset 0.
// - bit 12 of the default tag is its CFI bit, reset 0.
// - untagged host port frames take the default tag, also used when tagging them on egress; no egress tagging here, only the default_tag output.
// - untagged or null-vid ingress frames use the default vid for address lookup.
// - the ingress mode field picks counted frames: all, bc+mc+flood, bc+mc, bc only.
// - with count-gap set each frame is charged twelve extra bytes both ways.
// - with count-preamble set each frame is charged eight extra bytes both ways.
// - ingress rate low holds priority 1 code in bits 14-8 and priority 0 in 6-0.
// - ingress rate high holds priority 3 code in bits 14-8 and priority 2 in 6-0.
// - a zero code, the reset value, imposes no limit.
// - bit 7 of egress rate low enables egress limiting, reset off.
// - egress rate low holds priority 1 code in bits 14-8 and priority 0 in 6-0.
// - egress rate high holds priority 3 code in bits 14-8 and priority 2 in 6-0.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module host_port_tag_rate_limit_regs #(
  parameter int REFILL_CYC = host_port_regs_pkg::REFILL_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [host_port_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [host_port_regs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [host_port_regs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [host_port_regs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ing_valid,
  input wire logic ing_tagged,
  input wire logic [host_port_regs_pkg::REG_W-1:0] ing_tag,
  input wire logic [host_port_regs_pkg::PRIO_W-1:0] ing_prio,
  input wire logic [host_port_regs_pkg::LEN_W-1:0] ing_len,
  input wire logic ing_bcast,
  input wire logic ing_mcast,
  input wire logic ing_flood,
  input wire logic [63:0] ing_allow,
  output logic [host_port_regs_pkg::REG_W-1:0] ing_eff_tag,
  output logic [host_port_regs_pkg::VID_W-1:0] ing_lookup_vid,
  output logic ing_done,
  output logic ing_pass,
  output logic [27:0] ing_codes,
  input wire logic eg_valid,
  input wire logic [host_port_regs_pkg::PRIO_W-1:0] eg_prio,
  input wire logic [host_port_regs_pkg::LEN_W-1:0] eg_len,
  input wire logic [63:0] eg_allow,
  output logic eg_done,
  output logic eg_pass,
  output logic [27:0] eg_codes,
  output logic [host_port_regs_pkg::REG_W-1:0] default_tag
);
  localparam int RN = host_port_regs_pkg::REG_N;
  localparam int RW = host_port_regs_pkg::REG_W;
  localparam int IW = host_port_regs_pkg::IDX_W;
  localparam int CWD = host_port_regs_pkg::CODE_W;
  localparam int HI = host_port_regs_pkg::RATE_HI_LSB;
  localparam int LO = host_port_regs_pkg::RATE_LO_LSB;

  logic [RW-1:0] regs_reg [RN];
  logic aw_have_reg;
  logic w_have_reg;
  logic [IW-1:0] awidx_reg;
  logic [RW-1:0] wdata_reg;
  logic [1:0] wstrb_reg;
  logic [RW-1:0] eff_tag_next;
  logic [host_port_regs_pkg::VID_W-1:0] lookup_vid_next;

  rate_if ing_rif ();
  rate_if eg_rif ();

  // write path decode
  wire do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [RW-1:0] byte_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [RN-1:0] wr_hit;
  wire [RN-1:0] rd_hit;
  wire [IW-1:0] ar_idx = s_axi_araddr[host_port_regs_pkg::ADDR_W-1:2];
  wire wr_mapped = |wr_hit;
  wire rd_mapped = |rd_hit;
  logic [RW-1:0] rd_word;

  for (genvar i = 0; i < RN; i++) begin : g_reg
    assign wr_hit[i] = awidx_reg == host_port_regs_pkg::REG_IDX[i];
    assign rd_hit[i] = ar_idx == host_port_regs_pkg::REG_IDX[i];
    wire [RW-1:0] wmask = byte_mask & host_port_regs_pkg::REG_WMASK[i];
    wire [RW-1:0] reg_next = (regs_reg[i] & ~wmask) | (wdata_reg & wmask);
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        regs_reg[i] <= host_port_regs_pkg::REG_RST[i];
      end else if (do_wr && wr_hit[i]) begin
        regs_reg[i] <= reg_next;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    for (int k = 0; k < RN; k++) begin
      if (rd_hit[k]) begin
        rd_word = regs_reg[k];
      end
    end
  end

  // write address and data, taken in either order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_reg <= 1'b0;
      awidx_reg <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      awidx_reg <= s_axi_awaddr[host_port_regs_pkg::ADDR_W-1:2];
      s_axi_awready <= 1'b0;
    end else if (do_wr) begin
      aw_have_reg <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      wdata_reg <= s_axi_wdata[RW-1:0];
      wstrb_reg <= s_axi_wstrb[1:0];
      s_axi_wready <= 1'b0;
    end else if (do_wr) begin
      w_have_reg <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= host_port_regs_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? host_port_regs_pkg::RESP_OKAY : host_port_regs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= host_port_regs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_mapped ? host_port_regs_pkg::RESP_OKAY : host_port_regs_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // field views
  wire [RW-1:0] tag_q = regs_reg[host_port_regs_pkg::SEL_TAG];
  wire [RW-1:0] opt_q = regs_reg[host_port_regs_pkg::SEL_OPT];
  wire [1:0] mode = opt_q[host_port_regs_pkg::OPT_MODE_LSB +: 2];
  wire gap_en = opt_q[host_port_regs_pkg::OPT_GAP_BIT];
  wire pre_en = opt_q[host_port_regs_pkg::OPT_PRE_BIT];
  wire [RW-1:0] il_q = regs_reg[host_port_regs_pkg::SEL_ING_LO];
  wire [RW-1:0] ih_q = regs_reg[host_port_regs_pkg::SEL_ING_HI];
  wire [RW-1:0] el_q = regs_reg[host_port_regs_pkg::SEL_EG_LO];
  wire [RW-1:0] eh_q = regs_reg[host_port_regs_pkg::SEL_EG_HI];
  wire [4*CWD-1:0] ing_code_w = {ih_q[HI +: CWD], ih_q[LO +: CWD],
    il_q[HI +: CWD], il_q[LO +: CWD]};
  wire [4*CWD-1:0] eg_code_w = {eh_q[HI +: CWD], eh_q[LO +: CWD],
    el_q[HI +: CWD], el_q[LO +: CWD]};

  // ingress frame class against the limit mode
  wire bmc = ing_bcast || ing_mcast;
  wire ing_counted = (mode == host_port_regs_pkg::MODE_ALL) ||
    (mode == host_port_regs_pkg::MODE_BMC_FLOOD && (bmc || ing_flood)) ||
    (mode == host_port_regs_pkg::MODE_BMC && bmc) ||
    (mode == host_port_regs_pkg::MODE_BCAST && ing_bcast);

  default_tag_select u_tag_sel (
    .def_tag(tag_q),
    .frm_tagged(ing_tagged),
    .frm_tag(ing_tag),
    .eff_tag(eff_tag_next),
    .lookup_vid(lookup_vid_next)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ing_eff_tag <= '0;
      ing_lookup_vid <= '0;
    end else if (ing_valid) begin
      ing_eff_tag <= eff_tag_next;
      ing_lookup_vid <= lookup_vid_next;
    end
  end

  assign ing_rif.code = ing_code_w;
  assign ing_rif.allow = ing_allow;
  assign ing_rif.gap_en = gap_en;
  assign ing_rif.pre_en = pre_en;
  assign ing_rif.limit_en = 1'b1;
  assign ing_rif.frm_valid = ing_valid;
  assign ing_rif.frm_prio = ing_prio;
  assign ing_rif.frm_len = ing_len;
  assign ing_rif.frm_counted = ing_counted;
  assign eg_rif.code = eg_code_w;
  assign eg_rif.allow = eg_allow;
  assign eg_rif.gap_en = gap_en;
  assign eg_rif.pre_en = pre_en;
  assign eg_rif.limit_en = el_q[host_port_regs_pkg::EG_EN_BIT];
  assign eg_rif.frm_valid = eg_valid;
  assign eg_rif.frm_prio = eg_prio;
  assign eg_rif.frm_len = eg_len;
  assign eg_rif.frm_counted = 1'b1;

  rate_meter #(.REFILL_CYC(REFILL_CYC)) u_ing_meter (
    .clk(clk),
    .arst_n(arst_n),
    .rif(ing_rif.meter)
  );

  rate_meter #(.REFILL_CYC(REFILL_CYC)) u_eg_meter (
    .clk(clk),
    .arst_n(arst_n),
    .rif(eg_rif.meter)
  );

  assign ing_done = ing_rif.res_done;
  assign ing_pass = ing_rif.res_pass;
  assign eg_done = eg_rif.res_done;
  assign eg_pass = eg_rif.res_pass;
  assign ing_codes = ing_code_w;
  assign eg_codes = eg_code_w;
  assign default_tag = tag_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_tag_write;
    do_wr && wr_hit[0] && wstrb_reg == 2'h3 |=> default_tag == $past(wdata_reg);
  endproperty
  a_tag_write: assert property (p_tag_write) else $error("tag write lost");

  property p_untag_cfi;
    ing_valid && !ing_tagged |=> ing_eff_tag[12] == $past(default_tag[12]);
  endproperty
  a_untag_cfi: assert property (p_untag_cfi) else $error("cfi not default");

  property p_untag_tag;
    ing_valid && !ing_tagged |=> ing_eff_tag == $past(default_tag);
  endproperty
  a_untag_tag: assert property (p_untag_tag) else $error("untagged tag wrong");

  property p_lookup_vid;
    ing_valid && (!ing_tagged || ing_tag[11:0] == 12'h000)
      |=> ing_lookup_vid == $past(default_tag[11:0]);
  endproperty
  a_lookup_vid: assert property (p_lookup_vid) else $error("lookup vid wrong");

  property p_bcast_only;
    ing_valid && mode == 2'h3 && !ing_bcast |=> ing_done && ing_pass;
  endproperty
  a_bcast_only: assert property (p_bcast_only) else $error("non-broadcast limited");

  property p_ing_low_codes;
    do_wr && wr_hit[2] && wstrb_reg == 2'h3
      |=> ing_codes[13:0] == {$past(wdata_reg[14:8]), $past(wdata_reg[6:0])};
  endproperty
  a_ing_low_codes: assert property (p_ing_low_codes) else $error("ingress low codes");

  property p_ing_high_codes;
    do_wr && wr_hit[3] && wstrb_reg == 2'h3
      |=> ing_codes[27:14] == {$past(wdata_reg[14:8]), $past(wdata_reg[6:0])};
  endproperty
  a_ing_high_codes: assert property (p_ing_high_codes) else $error("ingress high codes");

  property p_eg_low_codes;
    do_wr && wr_hit[4] && wstrb_reg == 2'h3
      |=> eg_codes[13:0] == {$past(wdata_reg[14:8]), $past(wdata_reg[6:0])};
  endproperty
  a_eg_low_codes: assert property (p_eg_low_codes) else $error("egress low codes");

  property p_eg_high_codes;
    do_wr && wr_hit[5] && wstrb_reg == 2'h3
      |=> eg_codes[27:14] == {$past(wdata_reg[14:8]), $past(wdata_reg[6:0])};
  endproperty
  a_eg_high_codes: assert property (p_eg_high_codes) else $error("egress high codes");

  c_write_tag: cover property (do_wr && wr_hit[0]);
  c_read_back: cover property (s_axi_rvalid && s_axi_rresp == 2'h0);
  c_eg_limited: cover property (eg_done && !eg_pass);
endmodule : host_port_tag_rate_limit_regs

// file: rate_table_model.sv
// Purpose: stand-in for the external rate table behind the limit codes
// Assumes: 64 allowance bytes per code step per window
// Notes: code zero gives zero allowance, the meter must treat it as unlimited
`timescale 1ns/10ps
module rate_table_model (
  input wire logic [27:0] codes,
  output logic [63:0] allow
);
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      allow[p*16 +: 16] = {3'h0, codes[p*7 +: 7], 6'h00};
    end
  end
endmodule : rate_table_model

// file: host_port_tag_rate_limit_regs_test.sv
// Purpose: self-checking bench for the host port tag and rate limit registers
// Assumes: refill window shortened to 8 cycles
// Notes: frames are spaced so each one meets a freshly loaded bucket
`timescale 1ns/10ps
module host_port_tag_rate_limit_regs_test;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ing_valid = 1'h0, ing_tagged = 1'h0, eg_valid = 1'h0;
  logic ing_bcast = 1'h0, ing_mcast = 1'h0, ing_flood = 1'h0;
  logic [15:0] ing_tag = 16'h0, ing_eff_tag, default_tag;
  logic [1:0] ing_prio = 2'h0, eg_prio = 2'h0;
  logic [10:0] ing_len = 11'h0, eg_len = 11'h0;
  logic [63:0] ing_allow, eg_allow;
  logic [11:0] ing_lookup_vid;
  logic ing_done, ing_pass, eg_done, eg_pass;
  logic [27:0] ing_codes, eg_codes;
  logic [15:0] sh [6];
  logic [15:0] d;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  host_port_tag_rate_limit_regs #(.REFILL_CYC(8)) i_host_port_tag_rate_limit_regs (.clk, .arst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ing_valid,
    .ing_tagged, .ing_tag, .ing_prio, .ing_len, .ing_bcast, .ing_mcast, .ing_flood, .ing_allow,
    .ing_eff_tag, .ing_lookup_vid, .ing_done, .ing_pass, .ing_codes, .eg_valid, .eg_prio,
    .eg_len, .eg_allow, .eg_done, .eg_pass, .eg_codes, .default_tag);
  rate_table_model i_ing_table (.codes(ing_codes), .allow(ing_allow));
  rate_table_model i_eg_table (.codes(eg_codes), .allow(eg_allow));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      stop_test();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [11:0] ad(input int i);
    return {host_port_regs_pkg::REG_IDX[i], 2'h0};
  endfunction : ad

  task wr(input logic [11:0] a, input logic [15:0] v, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask : wr

  task rd(input logic [11:0] a, input logic [15:0] ev, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rresp, er);
    chk(s_axi_rdata, {16'h0000, ev});
  endtask : rd

  function automatic logic ep(input logic [1:0] m, input logic [2:0] c, input int cost,
    input int code, input logic en);
    logic cnt;
    cnt = (m == 2'h0) || (m == 2'h1 && c != 3'h0) || (m == 2'h2 && c[2:1] != 2'h0) || c[2];
    return !(cnt && en && code != 0 && cost > code * 64);
  endfunction : ep

  task frm(input logic eg, input logic [10:0] ln, input logic [2:0] c, input logic tg,
    input logic [15:0] tag, input logic e);
    repeat (10) @(posedge clk);
    ing_valid <= !eg;
    eg_valid <= eg;
    ing_len <= ln;
    eg_len <= ln;
    {ing_bcast, ing_mcast, ing_flood} <= c;
    ing_tagged <= tg;
    ing_tag <= tag;
    @(posedge clk);
    ing_valid <= 1'h0;
    eg_valid <= 1'h0;
    #1;
    if (eg) chk({eg_done, eg_pass}, {1'h1, e});
    else chk({ing_done, ing_pass}, {1'h1, e});
    if (!eg) chk(ing_eff_tag, tg ? tag : sh[0]);
    if (!eg) chk(ing_lookup_vid, (tg && tag[11:0] != 0) ? tag[11:0] : sh[0][11:0]);
  endtask : frm

  initial begin
    void'($urandom(32'h07CF00C5));
    repeat (8) @(posedge clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 6; i++) rd(ad(i), host_port_regs_pkg::REG_RST[i], 2'h0);
    rd(12'h004, 16'h0000, 2'h2);
    chk(default_tag, 16'h0001);
    $display("reset values done");
    repeat (3) begin
      for (int i = 0; i < 6; i++) begin
        d = 16'($urandom);
        sh[i] = d & host_port_regs_pkg::REG_WMASK[i];
        wr(ad(i), d, 2'h0);
        rd(ad(i), sh[i], 2'h0);
      end
    end
    wr(12'h2AC, 16'hFFFF, 2'h2);
    rd(ad(0), sh[0], 2'h0);
    chk(default_tag, sh[0]);
    chk(ing_codes, {sh[3][14:8], sh[3][6:0], sh[2][14:8], sh[2][6:0]});
    chk(eg_codes, {sh[5][14:8], sh[5][6:0], sh[4][14:8], sh[4][6:0]});
    $display("register access done");
    sh[0] = 16'($urandom) | 16'h0010;
    wr(ad(0), sh[0], 2'h0);
    wr(ad(2), 16'h0001, 2'h0);
    wr(ad(3), 16'h0000, 2'h0);
    wr(ad(1), 16'h0000, 2'h0);
    d = 16'($urandom);
    frm(1'h0, 11'd64, 3'h0, 1'h0, 16'h0, 1'h1);
    frm(1'h0, 11'd64, 3'h0, 1'h1, d & 16'hF000, 1'h1);
    frm(1'h0, 11'd64, 3'h0, 1'h1, d, 1'h1);
    for (int m = 0; m < 4; m++) begin
      wr(ad(1), {12'h000, 2'(m), 2'h3}, 2'h0);
      for (int k = 0; k < 4; k++) begin
        frm(1'h0, 11'd45, 3'((1 << k) >> 1), 1'h0, 16'h0, ep(2'(m), 3'((1 << k) >> 1), 65, 1, 1'h1));
      end
      frm(1'h0, 11'd44, 3'h4, 1'h0, 16'h0, 1'h1);
    end
    wr(ad(1), 16'h0002, 2'h0);
    frm(1'h0, 11'd53, 3'h4, 1'h0, 16'h0, 1'h0);
    wr(ad(1), 16'h0001, 2'h0);
    frm(1'h0, 11'd56, 3'h4, 1'h0, 16'h0, 1'h1);
    frm(1'h0, 11'd57, 3'h4, 1'h0, 16'h0, 1'h0);
    @(posedge clk) ing_prio <= 2'h1;
    frm(1'h0, 11'd500, 3'h4, 1'h0, 16'h0, 1'h1);
    $display("ingress limiting done");
    wr(ad(4), 16'h0001, 2'h0);
    frm(1'h1, 11'd500, 3'h0, 1'h0, 16'h0, 1'h1);
    wr(ad(4), 16'h0081, 2'h0);
    frm(1'h1, 11'd500, 3'h0, 1'h0, 16'h0, 1'h0);
    frm(1'h1, 11'd56, 3'h0, 1'h0, 16'h0, 1'h1);
    wr(ad(1), 16'h0003, 2'h0);
    frm(1'h1, 11'd45, 3'h0, 1'h0, 16'h0, 1'h0);
    $display("egress limiting done");
    stop_test();
  end
endmodule : host_port_tag_rate_limit_regs_test
